// >>> src/dpr_pkg.sv
// Shared constants, types and helpers for the 4,608-bit dual-port memory
`default_nettype none

package dpr_pkg;

  localparam int TOTAL_BITS = 4608;
  localparam int ROWS = 128;
  localparam int ROW_W = 36;
  localparam int ROW_AW = 7;
  localparam int ADDR_W = 12;
  localparam int BE_W = 4;
  localparam int LEN_W = 13;
  localparam int SHW_W = 6;

  // Reset values
  localparam logic [ROW_W-1:0] DATA_RST = 36'h0_0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
  localparam logic [BE_W-1:0] BE_RST = 4'hF;
  localparam logic CFG_ERR_RST = 1'b0;

  typedef enum logic [3:0] {
    W1 = 4'h0, W2 = 4'h1, W4 = 4'h2, W8 = 4'h3, W16 = 4'h4,
    W32 = 4'h5, W9 = 4'h6, W18 = 4'h7, W36 = 4'h8
  } dpr_width_e;

  typedef enum logic [2:0] {
    MODE_TDP = 3'h0, MODE_SDP = 3'h1, MODE_SP = 3'h2,
    MODE_FIFO = 3'h3, MODE_ROM = 3'h4, MODE_SHIFT = 3'h5
  } dpr_mode_e;

  function automatic logic [5:0] widthBits(input dpr_width_e w);
    case (w)
      W1: widthBits = 6'h01;
      W2: widthBits = 6'h02;
      W4: widthBits = 6'h04;
      W8: widthBits = 6'h08;
      W16: widthBits = 6'h10;
      W32: widthBits = 6'h20;
      W9: widthBits = 6'h09;
      W18: widthBits = 6'h12;
      W36: widthBits = 6'h24;
      default: widthBits = 6'h01;
    endcase
  endfunction

  function automatic logic isParity(input dpr_width_e w);
    isParity = (w == W9) || (w == W18) || (w == W36);
  endfunction

  function automatic logic [LEN_W-1:0] depthOf(input dpr_width_e w);
    case (w)
      W1: depthOf = 13'h1000;
      W2: depthOf = 13'h0800;
      W4: depthOf = 13'h0400;
      W8, W9: depthOf = 13'h0200;
      W16, W18: depthOf = 13'h0100;
      default: depthOf = 13'h0080;
    endcase
  endfunction

endpackage
`default_nettype wire

// >>> src/dpr_port_if.sv
// Carrier between one port's pipeline and its lane mapper and read extractor
`timescale 1ns/10ps
`default_nettype none

interface dpr_port_if;
  dpr_pkg::dpr_width_e width;
  logic [11:0] addr;
  logic [35:0] din;
  logic [3:0] byteEn;
  logic beUse;
  logic [6:0] row;
  logic [5:0] base;
  logic [35:0] mask;
  logic [35:0] data;
  logic [35:0] rowWord;
  logic [35:0] rdData;

  modport mapper (
    input width, addr, din, byteEn, beUse,
    output row, base, mask, data
  );
  modport reader (
    input width, base, rowWord,
    output rdData
  );
endinterface

`default_nettype wire

// >>> src/dpr_lane_map.sv
// Maps a port address and data onto one storage row with a write mask
`timescale 1ns/10ps
`default_nettype none

module dpr_lane_map (
  // Port view
  dpr_port_if.mapper port
);

  logic parity;
  logic allowBe;
  logic [5:0] w;
  logic [17:0] lin;
  wire [35:0] maskV;
  wire [35:0] dataV;

  always_comb begin
    w = dpr_pkg::widthBits(port.width);
    parity = dpr_pkg::isParity(port.width);
    lin = 18'(port.addr) * 18'(w);
    allowBe = port.beUse && ((port.width == dpr_pkg::W16) ||
      (port.width == dpr_pkg::W18) || (port.width == dpr_pkg::W32) ||
      (port.width == dpr_pkg::W36));
  end

  // Plain widths fill 32 of the 36 row bits and skip each ninth bit
  assign port.row = parity ? 7'(lin / 18'd36) : lin[11:5];
  assign port.base = parity ? 6'(lin % 18'd36) : {1'b0, lin[4:0]};

  for (genvar j = 0; j < 36; j++) begin : g_bit
    wire [6:0] lg = parity ? 7'(j) : 7'(j - j / 9);
    wire spare = !parity && (j % 9 == 8);
    wire [6:0] k = lg - {1'b0, port.base};
    wire hit = !spare && (lg >= {1'b0, port.base}) &&
      (lg < ({1'b0, port.base} + {1'b0, w}));
    // Nine-bit lanes with parity, eight-bit lanes without
    wire [1:0] lane = parity ? 2'(k / 7'd9) : 2'(k / 7'd8);
    assign dataV[j] = hit ? port.din[hit ? k[5:0] : 6'h00] : 1'b0;
    assign maskV[j] = hit && (!allowBe || port.byteEn[lane]);
  end

  assign port.mask = maskV;
  assign port.data = dataV;

endmodule // dpr_lane_map
`default_nettype wire

// >>> src/dpr_read_extract.sv
// Pulls one port-width word out of a storage row
`timescale 1ns/10ps
`default_nettype none

module dpr_read_extract (
  // Port view
  dpr_port_if.reader port
);

  logic parity;
  logic [5:0] w;
  wire [35:0] rdV;

  always_comb begin
    w = dpr_pkg::widthBits(port.width);
    parity = dpr_pkg::isParity(port.width);
  end

  for (genvar k = 0; k < 36; k++) begin : g_bit
    wire [6:0] lg = {1'b0, port.base} + 7'(k);
    wire [6:0] ph = parity ? lg : lg + (lg / 7'd8);
    wire ok = (7'(k) < {1'b0, w}) && (ph < 7'd36);
    // Bits above the port width read as zero
    assign rdV[k] = ok ? port.rowWord[ok ? ph[5:0] : 6'h00] : 1'b0;
  end

  assign port.rdData = rdV;

endmodule // dpr_read_extract
`default_nettype wire

// >>> src/dpr_ram4k.sv
// Dual-port 4,608-bit memory block with mode, width and shift support
//
// Contract
// - Storage holds 4,608 bits, parity positions included.
// - Modes: true dual, simple dual, single port, FIFO, ROM, shift.
// - RAM and ROM contents can be preloaded before operation.
// - Port organizations from 4096x1 down to 128x32 or 128x36.
// - True dual-port mode forbids the 32 and 36 bit organizations.
// - The two ports may use different widths over one array.
// - Mixed widths only within plain or parity family, except in ROM mode, which does not check it.
// - Shift register width times length times taps fits 4,608 bits.
// - Byte masking only for 16, 18, 32 or 36 bit writes.
// - Disabled byte lanes keep their previous contents.
// - Byte enable bits gate 9-bit lanes in ascending order.
// - Any combination of byte enables is accepted.
// - In 16 and 32 bit modes lanes are 8 bits wide.
// - Each register group may follow either port's clock enable.
// - Inputs always registered; only the output register is bypassable.
// - Shift mode reads a location before writing it each cycle.
// - Parity widths store one extra bit per byte.
`timescale 1ns/10ps
`default_nettype none

module dpr_ram4k (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration
  input wire dpr_pkg::dpr_mode_e mode,
  input wire dpr_pkg::dpr_width_e widthA,
  input wire dpr_pkg::dpr_width_e widthB,
  input wire logic bypassA,
  input wire logic bypassB,
  input wire logic inSelA,
  input wire logic inSelB,
  input wire logic outSelA,
  input wire logic outSelB,
  input wire logic beUseA,
  input wire logic beUseB,
  input wire logic [5:0] shiftWidth,
  input wire logic [12:0] shiftLen,
  // Port A
  input wire logic ceA,
  input wire logic renweA,
  input wire logic clrA,
  input wire logic [11:0] addrA,
  input wire logic [3:0] byteEnA,
  input wire logic [35:0] dinA,
  output logic [35:0] doutA,
  // Port B
  input wire logic ceB,
  input wire logic renweB,
  input wire logic clrB,
  input wire logic [11:0] addrB,
  input wire logic [3:0] byteEnB,
  input wire logic [35:0] dinB,
  output logic [35:0] doutB,
  // Preload
  input wire logic initWe,
  input wire logic [6:0] initRow,
  input wire logic [35:0] initData,
  // Status
  output logic cfgError
);

  // Storage array, parity columns included
  logic [35:0] mem [dpr_pkg::ROWS];

  logic [1:0] ce;
  logic [1:0] renwe;
  logic [1:0] clr;
  logic [1:0] bypass;
  logic [1:0] inSel;
  logic [1:0] outSel;
  logic [1:0] beUse;
  logic [1:0] canWr;
  logic [1:0] canRd;
  logic shiftOn;
  logic next_cfgError;
  logic [11:0] shiftPtr;
  logic [11:0] next_shiftPtr;
  logic [35:0] wordA;
  logic [35:0] wordB;
  logic [35:0] wordAB;
  dpr_pkg::dpr_width_e widthP [2];
  logic [11:0] addrP [2];
  logic [3:0] byteEnP [2];
  logic [35:0] dinP [2];
  wire [1:0] inCeW;
  wire [1:0] wrW;
  wire [6:0] rowP [2];
  wire [35:0] maskP [2];
  wire [35:0] dataP [2];
  wire [35:0] doutW [2];

  assign ce = {ceB, ceA};
  assign renwe = {renweB, renweA};
  assign clr = {clrB, clrA};
  assign bypass = {bypassB, bypassA};
  assign inSel = {inSelB, inSelA};
  assign outSel = {outSelB, outSelA};
  assign beUse = {beUseB, beUseA};
  assign widthP[0] = widthA;
  assign widthP[1] = widthB;
  assign addrP[0] = addrA;
  assign addrP[1] = addrB;
  assign byteEnP[0] = byteEnA;
  assign byteEnP[1] = byteEnB;
  assign dinP[0] = dinA;
  assign dinP[1] = dinB;
  assign shiftOn = (mode == dpr_pkg::MODE_SHIFT);

  // Which port may write and which may read in each mode
  always_comb begin
    case (mode)
      dpr_pkg::MODE_TDP: begin
        canWr = 2'h3;
        canRd = 2'h3;
      end
      dpr_pkg::MODE_SDP, dpr_pkg::MODE_FIFO: begin
        canWr = 2'h1;
        canRd = 2'h2;
      end
      dpr_pkg::MODE_SP: begin
        canWr = 2'h1;
        canRd = 2'h1;
      end
      dpr_pkg::MODE_ROM: begin
        canWr = 2'h0;
        canRd = 2'h3;
      end
      dpr_pkg::MODE_SHIFT: begin
        canWr = 2'h1;
        canRd = 2'h1;
      end
      default: begin
        canWr = 2'h0;
        canRd = 2'h0;
      end
    endcase
  end

  // Illegal combinations block both ports' writes until corrected; preload still writes
  always_comb begin
    next_cfgError = 1'b0;
    if (mode == dpr_pkg::MODE_TDP &&
        (widthA == dpr_pkg::W32 || widthA == dpr_pkg::W36 ||
         widthB == dpr_pkg::W32 || widthB == dpr_pkg::W36)) begin
      next_cfgError = 1'b1;
    end
    if ((mode == dpr_pkg::MODE_TDP || mode == dpr_pkg::MODE_SDP ||
         mode == dpr_pkg::MODE_FIFO) &&
        (dpr_pkg::isParity(widthA) != dpr_pkg::isParity(widthB))) begin
      next_cfgError = 1'b1;
    end
    // Word of taps times length may not exceed the array
    if (shiftOn && (shiftLen == 13'h0000 ||
        shiftLen > dpr_pkg::depthOf(widthA) || shiftWidth == 6'h00 ||
        shiftWidth > dpr_pkg::widthBits(widthA))) begin
      next_cfgError = 1'b1;
    end
    if (mode > dpr_pkg::MODE_SHIFT) begin
      next_cfgError = 1'b1;
    end
  end

  // Circular pointer gives a delay of shiftLen enable cycles per tap
  always_comb begin
    next_shiftPtr = shiftPtr;
    if (!shiftOn || clr[0]) begin
      next_shiftPtr = dpr_pkg::ADDR_RST;
    end else if (inCeW[0]) begin
      if ({1'b0, shiftPtr} >= shiftLen - 13'h0001) begin
        next_shiftPtr = dpr_pkg::ADDR_RST;
      end else begin
        next_shiftPtr = shiftPtr + 12'h001;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfgError <= dpr_pkg::CFG_ERR_RST;
      shiftPtr <= dpr_pkg::ADDR_RST;
    end else begin
      cfgError <= next_cfgError;
      shiftPtr <= next_shiftPtr;
    end
  end

  for (genvar p = 0; p < 2; p++) begin : g_port
    dpr_port_if pif ();
    logic inCe;
    logic outCe;
    logic rdExec;
    logic shiftHere;
    logic regValid;
    logic regWe;
    logic [11:0] regAddr;
    logic [3:0] regBe;
    logic [35:0] regDin;
    logic [35:0] rdHold;
    logic [35:0] dout;
    logic next_regValid;
    logic next_regWe;
    logic [11:0] next_regAddr;
    logic [3:0] next_regBe;
    logic [35:0] next_regDin;
    logic [35:0] next_rdHold;
    logic [35:0] next_dout;
    logic [35:0] lowMask;
    logic [35:0] wordMask;
    logic [35:0] shiftWord;

    assign inCe = inSel[p] ? ce[1] : ce[0];
    assign outCe = outSel[p] ? ce[1] : ce[0];
    assign shiftHere = shiftOn && (p == 0);
    assign inCeW[p] = inCe;

    // Older taps move up by one tap width, new data enters at bit 0
    always_comb begin
      lowMask = (36'h0_0000_0001 << shiftWidth) - 36'h0_0000_0001;
      wordMask = (36'h0_0000_0001 << dpr_pkg::widthBits(widthP[p])) -
        36'h0_0000_0001;
      shiftWord = ((pif.rdData << shiftWidth) | (regDin & lowMask)) &
        wordMask;
    end

    assign pif.width = widthP[p];
    assign pif.addr = regAddr;
    assign pif.byteEn = regBe;
    assign pif.beUse = beUse[p] && !shiftHere;
    assign pif.din = shiftHere ? shiftWord : regDin;
    assign pif.rowWord = mem[pif.row];

    dpr_lane_map u_map (
      .port(pif.mapper)
    );

    dpr_read_extract u_rd (
      .port(pif.reader)
    );

    // Shift mode reads the old word in the same cycle it is replaced
    assign rdExec = regValid && (shiftHere || (!regWe && canRd[p]));

    always_comb begin
      next_regValid = 1'b0;
      next_regWe = regWe;
      next_regAddr = regAddr;
      next_regBe = regBe;
      next_regDin = regDin;
      if (!clr[p] && inCe) begin
        next_regValid = 1'b1;
        next_regWe = shiftHere || (renwe[p] && canWr[p]);
        next_regAddr = shiftHere ? shiftPtr : addrP[p];
        next_regBe = byteEnP[p];
        next_regDin = dinP[p];
      end
      next_rdHold = rdExec ? pif.rdData : rdHold;
      next_dout = dout;
      if (clr[p]) begin
        next_dout = dpr_pkg::DATA_RST;
      end else if (bypass[p]) begin
        if (rdExec) begin
          next_dout = pif.rdData;
        end
      end else if (outCe) begin
        next_dout = rdHold;
      end
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        regValid <= 1'b0;
        regWe <= 1'b0;
        regAddr <= dpr_pkg::ADDR_RST;
        regBe <= dpr_pkg::BE_RST;
        regDin <= dpr_pkg::DATA_RST;
        rdHold <= dpr_pkg::DATA_RST;
        dout <= dpr_pkg::DATA_RST;
      end else begin
        regValid <= next_regValid;
        regWe <= next_regWe;
        regAddr <= next_regAddr;
        regBe <= next_regBe;
        regDin <= next_regDin;
        rdHold <= next_rdHold;
        dout <= next_dout;
      end
    end

    assign wrW[p] = regValid && regWe && !cfgError && !initWe;
    assign rowP[p] = pif.row;
    assign maskP[p] = pif.mask;
    assign dataP[p] = pif.data;
    assign doutW[p] = dout;
  end

  assign doutA = doutW[0];
  assign doutB = doutW[1];

  // Masked merge; on a shared row port B lands after port A
  always_comb begin
    wordA = (mem[rowP[0]] & ~maskP[0]) | (dataP[0] & maskP[0]);
    wordB = (mem[rowP[1]] & ~maskP[1]) | (dataP[1] & maskP[1]);
    wordAB = (wordA & ~maskP[1]) | (dataP[1] & maskP[1]);
  end

  // Array has no reset: contents hold until written or preloaded
  always_ff @(posedge clk) begin
    if (initWe) begin
      mem[initRow] <= initData;
    end else if (wrW[0] && wrW[1] && rowP[0] == rowP[1]) begin
      mem[rowP[0]] <= wordAB;
    end else begin
      if (wrW[0]) begin
        mem[rowP[0]] <= wordA;
      end
      if (wrW[1]) begin
        mem[rowP[1]] <= wordB;
      end
    end
  end

endmodule // dpr_ram4k
`default_nettype wire

// >>> verification/dpr_ram4k_asserts.sv
// Port-level checker for the dual-port memory block
`timescale 1ns/10ps
`default_nettype none
module dpr_ram4k_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration
  input wire dpr_pkg::dpr_mode_e mode,
  input wire dpr_pkg::dpr_width_e widthA,
  input wire dpr_pkg::dpr_width_e widthB,
  input wire logic [5:0] shiftWidth,
  // Port controls
  input wire logic ceA,
  input wire logic ceB,
  input wire logic clrA,
  input wire logic clrB,
  // Results
  input wire logic [35:0] doutA,
  input wire logic [35:0] doutB,
  input wire logic cfgError
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Two idle edges cover both the bypassed and the registered read path
  sequence quietA;
    !ceA && !ceB && !clrA;
  endsequence
  sequence quietB;
    !ceA && !ceB && !clrB;
  endsequence
  a_tdp_wide_err: assert property (
    mode == dpr_pkg::MODE_TDP && widthA == dpr_pkg::W36 |=> cfgError)
    else $error("wide true dual-port not flagged");
  a_family_mix_err: assert property (
    mode == dpr_pkg::MODE_SDP && widthA == dpr_pkg::W9 &&
    widthB == dpr_pkg::W8 |=> cfgError)
    else $error("family mix not flagged");
  a_legal_mix_ok: assert property (
    mode == dpr_pkg::MODE_SDP && widthA == dpr_pkg::W18 &&
    widthB == dpr_pkg::W36 |=> !cfgError)
    else $error("legal mixed width flagged");
  a_shift_size_err: assert property (
    mode == dpr_pkg::MODE_SHIFT && shiftWidth == 6'h00 |=> cfgError)
    else $error("zero shift width not flagged");
  a_clear_zero_a: assert property (
    clrA |=> doutA == 36'h0)
    else $error("port A output not cleared");
  a_clear_zero_b: assert property (
    clrB |=> doutB == 36'h0)
    else $error("port B output not cleared");
  a_hold_quiet_a: assert property (
    quietA ##1 quietA |=> $stable(doutA))
    else $error("port A output moved while idle");
  a_hold_quiet_b: assert property (
    quietB ##1 quietB |=> $stable(doutB))
    else $error("port B output moved while idle");
endmodule // dpr_ram4k_asserts
bind dpr_ram4k dpr_ram4k_asserts chk_u (
  .clk, .rst, .mode, .widthA, .widthB, .shiftWidth, .ceA, .ceB,
  .clrA, .clrB, .doutA, .doutB, .cfgError
);
`default_nettype wire

// >>> verification/dpr_user_port.sv
// Fabric user logic that presents requests on memory port B
`timescale 1ns/10ps
`default_nettype none
module dpr_user_port (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request from the bench
  input wire logic go,
  input wire logic wr,
  input wire logic [11:0] reqAddr,
  input wire logic [35:0] reqData,
  // Port pins toward the memory
  output logic ce,
  output logic renwe,
  output logic [11:0] addr,
  output logic [35:0] din
);
  // Idle fields toggle so a stale request never passes for a live one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ce <= 1'b0;
      renwe <= 1'b0;
      addr <= 12'h000;
      din <= 36'h0;
    end else begin
      ce <= go;
      renwe <= go ? wr : ~renwe;
      addr <= go ? reqAddr : ~addr;
      din <= go ? reqData : ~din;
    end
  end
endmodule // dpr_user_port
`default_nettype wire

// >>> verification/test_dpr_ram4k.sv
// Self-checking bench for the dual-port memory block
`timescale 1ns/10ps
`default_nettype none
module test_dpr_ram4k;
  logic clk = 1'b0;
  logic rst = 1'b1;
  dpr_pkg::dpr_mode_e mode = dpr_pkg::MODE_SDP;
  dpr_pkg::dpr_width_e widthA = dpr_pkg::W36;
  dpr_pkg::dpr_width_e widthB = dpr_pkg::W36;
  logic bypassA = 1'b1;
  logic inSelA = 1'b0;
  logic beUseA = 1'b1;
  logic [5:0] shiftWidth = 6'h08;
  logic [12:0] shiftLen = 13'h0003;
  logic ceA = 1'b0;
  logic renweA = 1'b0;
  logic clrA = 1'b0;
  logic clrB = 1'b0;
  logic [11:0] addrA = 12'h000;
  logic [3:0] byteEnA = 4'hF;
  logic [35:0] dinA = 36'h0;
  logic initWe = 1'b0;
  logic [6:0] initRow = 7'h00;
  logic [35:0] initData = 36'h0;
  logic goB = 1'b0;
  logic [11:0] reqAddr = 12'h000;
  logic [35:0] reqData = 36'h0;
  logic ceB, renweB, cfgError;
  logic [11:0] addrB;
  logic [35:0] dinB, doutA, doutB, got, exp;
  int n_errors = 0;
  int n_checks = 0;
  always #5 clk = ~clk;
  dpr_ram4k dut_u (
    .clk, .rst, .mode, .widthA, .widthB, .bypassA, .bypassB(bypassA),
    .inSelA, .inSelB(1'b1), .outSelA(1'b0), .outSelB(1'b1),
    .beUseA, .beUseB(beUseA), .shiftWidth, .shiftLen, .ceA, .renweA,
    .clrA, .addrA, .byteEnA, .dinA, .doutA, .ceB, .renweB, .clrB,
    .addrB, .byteEnB(byteEnA), .dinB, .doutB, .initWe, .initRow,
    .initData, .cfgError
  );
  dpr_user_port user_u (
    .clk, .rst, .go(goB), .wr(1'b0), .reqAddr, .reqData, .ce(ceB),
    .renwe(renweB), .addr(addrB), .din(dinB)
  );
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [35:0] seen,
      input logic [35:0] want);
    n_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", what, want, seen);
    end
  endtask
  task automatic setCfg(input dpr_pkg::dpr_mode_e m,
      input dpr_pkg::dpr_width_e wa, input dpr_pkg::dpr_width_e wb);
    mode = m;
    widthA = wa;
    widthB = wb;
    repeat (2) step();
  endtask
  task automatic wrA(input logic [11:0] a, input logic [35:0] d,
      input logic [3:0] be);
    ceA = 1'b1;
    renweA = 1'b1;
    addrA = a;
    dinA = d;
    byteEnA = be;
    step();
    ceA = 1'b0;
    // One idle edge so a following request never re-raises the enable
    step();
  endtask
  // Registered path needs the enable held until the output loads
  task automatic rdA(input logic [11:0] a);
    ceA = 1'b1;
    renweA = 1'b0;
    addrA = a;
    repeat (bypassA ? 1 : 3) step();
    ceA = 1'b0;
    step();
    got = doutA;
  endtask
  task automatic rdB(input logic [11:0] a);
    goB = 1'b1;
    reqAddr = a;
    step();
    goB = 1'b0;
    repeat (2) step();
    got = doutB;
  endtask
  task automatic t_cfg();
    setCfg(dpr_pkg::MODE_TDP, dpr_pkg::W36, dpr_pkg::W36);
    chk("tdpWide", {35'h0, cfgError}, 36'h1);
    setCfg(dpr_pkg::MODE_TDP, dpr_pkg::W16, dpr_pkg::W8);
    chk("tdpMix", {35'h0, cfgError}, 36'h0);
    setCfg(dpr_pkg::MODE_SDP, dpr_pkg::W9, dpr_pkg::W8);
    chk("familyMix", {35'h0, cfgError}, 36'h1);
    setCfg(dpr_pkg::MODE_SDP, dpr_pkg::W18, dpr_pkg::W36);
    chk("parityMix", {35'h0, cfgError}, 36'h0);
    shiftWidth = 6'h00;
    setCfg(dpr_pkg::MODE_SHIFT, dpr_pkg::W8, dpr_pkg::W8);
    chk("shiftZero", {35'h0, cfgError}, 36'h1);
    shiftWidth = 6'h08;
    setCfg(dpr_pkg::MODE_FIFO, dpr_pkg::W9, dpr_pkg::W8);
    chk("fifoMix", {35'h0, cfgError}, 36'h1);
    setCfg(dpr_pkg::dpr_mode_e'(3'h6), dpr_pkg::W8, dpr_pkg::W8);
    chk("badMode", {35'h0, cfgError}, 36'h1);
    $display("done cfg");
  endtask
  task automatic t_lanes();
    setCfg(dpr_pkg::MODE_SDP, dpr_pkg::W36, dpr_pkg::W36);
    for (int be = 0; be < 16; be++) begin
      wrA(12'h003, 36'hF_FFFF_FFFF, 4'hF);
      wrA(12'h003, 36'h0, be[3:0]);
      exp = 36'hF_FFFF_FFFF;
      for (int i = 0; i < 4; i++) begin
        if (be[i]) exp[9*i +: 9] = 9'h000;
      end
      rdB(12'h003);
      chk("mask36", got, exp);
    end
    beUseA = 1'b0;
    wrA(12'h009, 36'h1_2345_6789, 4'h0);
    rdB(12'h009);
    chk("beUnused", got, 36'h1_2345_6789);
    beUseA = 1'b1;
    setCfg(dpr_pkg::MODE_SDP, dpr_pkg::W32, dpr_pkg::W32);
    wrA(12'h005, 36'hF_FFFF_FFFF, 4'hF);
    wrA(12'h005, 36'h0, 4'h5);
    rdB(12'h005);
    chk("mask32", got, 36'h0_FF00_FF00);
    setCfg(dpr_pkg::MODE_SDP, dpr_pkg::W8, dpr_pkg::W8);
    wrA(12'h007, 36'h0_0000_005A, 4'h0);
    rdB(12'h007);
    chk("w8NoMask", got, 36'h0_0000_005A);
    $display("done lanes");
  endtask
  task automatic t_mixed();
    setCfg(dpr_pkg::MODE_SDP, dpr_pkg::W8, dpr_pkg::W16);
    wrA(12'h000, 36'h0_0000_00A5, 4'hF);
    wrA(12'h001, 36'h0_0000_003C, 4'hF);
    rdB(12'h000);
    chk("mixPlain", got, 36'h0_0000_3CA5);
    setCfg(dpr_pkg::MODE_SDP, dpr_pkg::W9, dpr_pkg::W18);
    wrA(12'h000, 36'h0_0000_01A5, 4'hF);
    wrA(12'h001, 36'h0_0000_00C3, 4'hF);
    rdB(12'h000);
    chk("mixParity", got, 36'h0_0001_87A5);
    $display("done mixed");
  endtask
  // Port A input registers follow port B's enable; top row proves depth
  task automatic t_insel();
    setCfg(dpr_pkg::MODE_SDP, dpr_pkg::W36, dpr_pkg::W36);
    inSelA = 1'b1;
    renweA = 1'b1;
    addrA = 12'h07F;
    dinA = 36'hA_5A5A_5A5A;
    byteEnA = 4'hF;
    goB = 1'b1;
    reqAddr = 12'h07F;
    step();
    goB = 1'b0;
    repeat (2) step();
    inSelA = 1'b0;
    renweA = 1'b0;
    rdB(12'h07F);
    chk("inSelB", got, 36'hA_5A5A_5A5A);
    $display("done insel");
  endtask
  task automatic t_rom();
    setCfg(dpr_pkg::MODE_ROM, dpr_pkg::W36, dpr_pkg::W36);
    initWe = 1'b1;
    initRow = 7'h05;
    initData = 36'h9_8765_4321;
    step();
    initWe = 1'b0;
    wrA(12'h005, 36'h0, 4'hF);
    rdA(12'h005);
    chk("romPreload", got, 36'h9_8765_4321);
    $display("done rom");
  endtask
  task automatic t_shift();
    setCfg(dpr_pkg::MODE_SHIFT, dpr_pkg::W8, dpr_pkg::W8);
    clrA = 1'b1;
    step();
    clrA = 1'b0;
    ceA = 1'b1;
    renweA = 1'b1;
    for (int j = 0; j < 10; j++) begin
      dinA = 36'(j + 1);
      step();
      if (j > 3) chk("shiftTap", doutA, 36'(j - 3));
    end
    ceA = 1'b0;
    $display("done shift");
  endtask
  task automatic t_clear();
    setCfg(dpr_pkg::MODE_SP, dpr_pkg::W36, dpr_pkg::W36);
    bypassA = 1'b0;
    wrA(12'h002, 36'h5_A5A5_A5A5, 4'hF);
    rdA(12'h002);
    chk("regRead", got, 36'h5_A5A5_A5A5);
    clrA = 1'b1;
    clrB = 1'b1;
    step();
    clrA = 1'b0;
    clrB = 1'b0;
    step();
    chk("clearA", doutA, 36'h0);
    chk("clearB", doutB, 36'h0);
    bypassA = 1'b1;
    $display("done clear");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    t_cfg();
    t_lanes();
    t_mixed();
    t_insel();
    t_rom();
    t_shift();
    t_clear();
    end_sim();
  end
endmodule // test_dpr_ram4k
`default_nettype wire
